//--- core/slp_sequencer.sv
// Sleep-state mode controller with gate sequencing and register slave
// Contract
// - Power up into S5, all regulators off
// - S5 to S0 needs three goods, sleep low
// - Sleep rising edge in S0 enters S3
// - Sleep low in S3 returns to S0
// - Supply-good loss in S0 returns to S5
// - Never S3 to S5 or S5 to S3
// - Control idle until reference good
// - Standby monitor first, then gate monitor
// - Gate supply good, sleep low: start soft-start
// - Rail regulated, soft-start done: raise in-regulation
// - Each monitor flags its own supply good
// - S3: memory standby, termination off, core low
// - S5: regulators off, all gates low
// - S0 250 kHz switching, S3 doubled
// - High and low gates never overlap
// - S0 overcurrent latches off until supply cycled
// - S3 gate-supply loss drops flag, stays S3
// - Thermal shutdown above 145, resume below 120
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
module slp_sequencer (
    input  logic               aclk,
    input  logic               aresetn,
    input  slp_pkg::slp_sense_t sense,
    output slp_pkg::slp_gate_t gate,
    output logic               standby_supply_good,
    output logic               gate_supply_good,
    output logic               memory_rail_in_regulation,
    output logic               termination_enable,
    output logic               core_rail_enable,
    output logic [1:0]         sleep_mode,
    input  logic               awvalid,
    output logic               awready,
    input  logic [3:0]         awaddr,
    input  logic               wvalid,
    output logic               wready,
    input  logic [31:0]        wdata,
    input  logic [3:0]         wstrb,
    output logic               bvalid,
    input  logic               bready,
    output logic [1:0]         bresp,
    input  logic               arvalid,
    output logic               arready,
    input  logic [3:0]         araddr,
    output logic               rvalid,
    input  logic               rready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp
);
    import slp_pkg::*;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    logic [SENSE_W-1:0] meta_q;
    logic [SENSE_W-1:0] sync_q;
    slp_sense_t         s;
    // First stage feeds only the second stage
    for (genvar i = 0; i < SENSE_W; i++) begin : g_sync
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= sense[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end
    assign s = slp_sense_t'(sync_q);

    // ------------------------------------------------------------
    // Supply monitors, thermal and mode state
    // ------------------------------------------------------------
    slp_state_t  st_q, st_d;
    logic        sb_good_q, sb_good_d;
    logic        gs_good_q, gs_good_d;
    logic        therm_q, therm_d;
    logic        slp_prev_q, slp_prev_d;
    logic        inreg_q, inreg_d;
    logic [15:0] ss_q, ss_d;
    logic        ss_done;
    logic        slp_rise;

    assign ss_done  = (ss_q == 16'(SS_CYC));
    assign slp_rise = s.sleep_request && !slp_prev_q;

    // Mode decision; thermal shutdown freezes the mode so that no
    // forbidden S3/S5 jump is ever taken while the die is hot
    always_comb begin
        sb_good_d  = s.reference_good && s.standby_supply_ok;
        gs_good_d  = s.reference_good && sb_good_q
                     && s.main_supply_ok;
        therm_d    = therm_q;
        if (s.temp_hot)
            therm_d = 1'b1;
        else if (s.temp_cool)
            therm_d = 1'b0;
        slp_prev_d = s.sleep_request;
        st_d       = st_q;
        ss_d       = ss_q;
        inreg_d    = inreg_q;
        if (!therm_q) begin
            case (st_q)
                ST_S5: begin
                    ss_d    = 16'h0000;
                    inreg_d = 1'b0;
                    // Monitors already need the reference, so the
                    // mode stays idle without it
                    if (s.reference_good && sb_good_q && gs_good_q
                        && !s.sleep_request)
                        st_d = ST_SOFT;
                end
                ST_SOFT: begin
                    if (!ss_done)
                        ss_d = ss_q + 16'h0001;
                    if (s.overcurrent)
                        st_d = ST_TRIP;
                    else if (!sb_good_q || !gs_good_q)
                        st_d = ST_S5;
                    else if (ss_done && s.memory_rail_ok) begin
                        inreg_d = 1'b1;
                        st_d    = ST_S0;
                    end
                end
                ST_S0: begin
                    if (s.overcurrent)
                        st_d = ST_TRIP;
                    else if (!sb_good_q || !gs_good_q)
                        st_d = ST_S5;
                    else if (slp_rise)
                        st_d = ST_S3;
                end
                ST_S3: begin
                    // Overcurrent and gate-supply loss ignored here
                    if (!s.sleep_request)
                        st_d = ST_S0;
                end
                ST_TRIP: begin
                    inreg_d = 1'b0;
                    if (!s.standby_supply_ok || !s.main_supply_ok)
                        st_d = ST_S5;
                end
                default: st_d = ST_S5;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q       <= ST_S5;
            sb_good_q  <= 1'b0;
            gs_good_q  <= 1'b0;
            therm_q    <= 1'b0;
            slp_prev_q <= 1'b0;
            inreg_q    <= 1'b0;
            ss_q       <= 16'h0000;
        end else begin
            st_q       <= st_d;
            sb_good_q  <= sb_good_d;
            gs_good_q  <= gs_good_d;
            therm_q    <= therm_d;
            slp_prev_q <= slp_prev_d;
            inreg_q    <= inreg_d;
            ss_q       <= ss_d;
        end
    end

    // ------------------------------------------------------------
    // PWM timebase and gate drive
    // ------------------------------------------------------------
    logic [7:0] mem_duty_q, core_duty_q;
    logic [7:0] cnt_q, cnt_d, per, cmp, ccnt, ccmp;
    logic       mem_on, core_on;
    slp_gate_t  gate_d;
    logic       term_d, core_en_d;
    logic [1:0] mode_d;

    // S3 halves the period, so the memory rail switches twice as fast
    always_comb begin
        per     = (st_q == ST_S3) ? 8'(PWM_S3_CYC) : 8'(PWM_S0_CYC);
        cnt_d   = (cnt_q >= per - 8'h01) ? 8'h00 : cnt_q + 8'h01;
        cmp     = (st_q == ST_S3) ? (mem_duty_q >> 1) : mem_duty_q;
        if (cmp > per)
            cmp = per;
        // Core runs half a period behind to spread input current
        ccnt    = (cnt_q >= 8'(PWM_S3_CYC)) ? cnt_q - 8'(PWM_S3_CYC)
                                            : cnt_q + 8'(PWM_S3_CYC);
        ccmp    = (core_duty_q > 8'(PWM_S0_CYC)) ? 8'(PWM_S0_CYC)
                                                 : core_duty_q;
        mem_on  = !therm_q && (st_q == ST_SOFT || st_q == ST_S0
                               || st_q == ST_S3);
        core_on = !therm_q && st_q == ST_S0 && inreg_q;
        // Dead band on both edges keeps the pair from overlapping
        gate_d.memory_high_side_gate = mem_on && cnt_q >= 8'(DEAD_CYC)
            && cnt_q < cmp;
        gate_d.memory_low_side_gate = mem_on
            && cnt_q >= cmp + 8'(DEAD_CYC)
            && cnt_q < per - 8'(DEAD_CYC);
        gate_d.core_high_side_gate = core_on && ccnt >= 8'(DEAD_CYC)
            && ccnt < ccmp;
        gate_d.core_low_side_gate = core_on
            && ccnt >= ccmp + 8'(DEAD_CYC)
            && ccnt < 8'(PWM_S0_CYC - DEAD_CYC);
        term_d    = core_on;
        core_en_d = core_on;
        case (st_q)
            ST_S0, ST_SOFT: mode_d = 2'h1;
            ST_S3:          mode_d = 2'h3;
            default:        mode_d = 2'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q                     <= 8'h00;
            gate                      <= '0;
            termination_enable        <= 1'b0;
            core_rail_enable          <= 1'b0;
            sleep_mode                <= 2'h0;
            standby_supply_good       <= 1'b0;
            gate_supply_good          <= 1'b0;
            memory_rail_in_regulation <= 1'b0;
        end else begin
            cnt_q                     <= cnt_d;
            gate                      <= gate_d;
            termination_enable        <= term_d;
            core_rail_enable          <= core_en_d;
            sleep_mode                <= mode_d;
            standby_supply_good       <= sb_good_q;
            gate_supply_good          <= gs_good_q;
            memory_rail_in_regulation <= inreg_q;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [3:0]  wa_q, wa_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0]  ws_q, ws_d;
    logic        bvalid_d, rvalid_d, awready_d, wready_d, arready_d;
    logic [1:0]  bresp_d, rresp_d;
    logic [31:0] rdata_d;
    logic [7:0]  mem_duty_d, core_duty_d;

    // Address and data may come in either order; answer when both held
    always_comb begin
        aw_have_d   = aw_have_q;
        w_have_d    = w_have_q;
        wa_d        = wa_q;
        wd_d        = wd_q;
        ws_d        = ws_q;
        bvalid_d    = bvalid && !bready;
        bresp_d     = bresp;
        rvalid_d    = rvalid && !rready;
        rresp_d     = rresp;
        rdata_d     = rdata;
        mem_duty_d  = mem_duty_q;
        core_duty_d = core_duty_q;
        if (awvalid && awready) begin
            aw_have_d = 1'b1;
            wa_d      = awaddr;
        end
        if (wvalid && wready) begin
            w_have_d = 1'b1;
            wd_d     = wdata;
            ws_d     = wstrb;
        end
        if (aw_have_q && w_have_q && !bvalid) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            if (wa_q == ADDR_CTRL) begin
                if (ws_q[0])
                    mem_duty_d = wd_q[CTRL_MEM_LSB +: 8];
                if (ws_q[1])
                    core_duty_d = wd_q[CTRL_CORE_LSB +: 8];
            end else if (wa_q != ADDR_STAT)
                bresp_d = RESP_SLV;
        end
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            case (araddr)
                ADDR_CTRL: rdata_d = {16'h0000, core_duty_q, mem_duty_q};
                ADDR_STAT: rdata_d = {24'h000000, therm_q, inreg_q,
                                      gs_good_q, sb_good_q, 1'b0,
                                      3'(st_q)};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = RESP_SLV;
                end
            endcase
        end
        awready_d = !aw_have_d && !(awvalid && awready);
        wready_d  = !w_have_d && !(wvalid && wready);
        arready_d = !rvalid_d && !(arvalid && arready);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q   <= 1'b0;
            w_have_q    <= 1'b0;
            wa_q        <= 4'h0;
            wd_q        <= 32'h00000000;
            ws_q        <= 4'h0;
            awready     <= 1'b0;
            wready      <= 1'b0;
            arready     <= 1'b0;
            bvalid      <= 1'b0;
            bresp       <= 2'h0;
            rvalid      <= 1'b0;
            rresp       <= 2'h0;
            rdata       <= 32'h00000000;
            mem_duty_q  <= DUTY_RST;
            core_duty_q <= DUTY_RST;
        end else begin
            aw_have_q   <= aw_have_d;
            w_have_q    <= w_have_d;
            wa_q        <= wa_d;
            wd_q        <= wd_d;
            ws_q        <= ws_d;
            awready     <= awready_d;
            wready      <= wready_d;
            arready     <= arready_d;
            bvalid      <= bvalid_d;
            bresp       <= bresp_d;
            rvalid      <= rvalid_d;
            rresp       <= rresp_d;
            rdata       <= rdata_d;
            mem_duty_q  <= mem_duty_d;
            core_duty_q <= core_duty_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ramp_done;
        st_q == ST_SOFT ##1 st_q == ST_S0;
    endsequence

    chk_reset_s5: assert property (
        !$past(aresetn) |-> st_q == ST_S5 && gate == '0)
        else $error("not in S5 after reset");
    chk_no_s3_s5: assert property (
        (st_q == ST_S3 |=> st_q != ST_S5)
        and (st_q == ST_S5 |=> st_q != ST_S3))
        else $error("direct S3/S5 transition");
    chk_sleep_enter: assert property (
        st_q == ST_S0 && !therm_q && slp_rise && !s.overcurrent
        && sb_good_q && gs_good_q |=> st_q == ST_S3)
        else $error("sleep edge did not enter S3");
    chk_wake_s0: assert property (
        st_q == ST_S3 && !therm_q && !s.sleep_request |=> st_q == ST_S0)
        else $error("S3 did not return to S0");
    chk_loss_s5: assert property (
        st_q == ST_S0 && !therm_q && !s.overcurrent && !gs_good_q
        |=> st_q == ST_S5)
        else $error("supply loss kept S0");
    chk_ref_idle: assert property (
        st_q == ST_S5 && !s.reference_good |=> st_q == ST_S5)
        else $error("left S5 without reference");
    chk_mon_order: assert property (
        $rose(gs_good_q) |-> $past(sb_good_q))
        else $error("gate monitor before standby");
    chk_inreg_ramp: assert property (
        s_ramp_done |-> inreg_q ##2 core_rail_enable || therm_q
        || st_q != ST_S0)
        else $error("in-regulation not raised");
    chk_s5_gates: assert property (
        st_q == ST_S5 ##1 st_q == ST_S5 |-> gate == '0
        && !termination_enable && !core_rail_enable)
        else $error("gates active in S5");
    chk_s3_core: assert property (
        st_q == ST_S3 ##1 st_q == ST_S3 |-> !gate.core_high_side_gate
        && !gate.core_low_side_gate && !termination_enable)
        else $error("core active in S3");
    chk_no_overlap: assert property (
        !(gate.memory_high_side_gate && gate.memory_low_side_gate)
        && !(gate.core_high_side_gate && gate.core_low_side_gate))
        else $error("gate overlap");
    chk_pwm_period: assert property (
        cnt_q == 8'h00 && st_q == ST_S0 ##1 st_q == ST_S0 [*8]
        |-> cnt_q == 8'h08)
        else $error("PWM count off");
    chk_trip_hold: assert property (
        st_q == ST_TRIP && s.standby_supply_ok && s.main_supply_ok
        |=> st_q == ST_TRIP)
        else $error("trip released without supply cycle");
endmodule : slp_sequencer

//--- core/slp_pkg.sv
// Package: types and constants of the sleep-state sequencer
package slp_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 25_000_000;
    localparam int PWM_S0_HZ   = 250_000;
    localparam int DEAD_NS     = 80;
    localparam int SS_US       = 100;
    localparam int PWM_S0_CYC  = CLK_HZ / PWM_S0_HZ;
    localparam int PWM_S3_CYC  = PWM_S0_CYC / 2;
    localparam int DEAD_CYC    = (DEAD_NS * (CLK_HZ / 1_000_000) + 999)
                                 / 1000;
    localparam int SS_CYC      = SS_US * (CLK_HZ / 1_000_000);
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W     = 4;
    localparam logic [3:0]  ADDR_CTRL  = 4'h0;
    localparam logic [3:0]  ADDR_STAT  = 4'h4;
    localparam logic [7:0]  DUTY_RST   = 8'h32;
    localparam int          CTRL_MEM_LSB  = 0;
    localparam int          CTRL_CORE_LSB = 8;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;

    // Mode controller states; SOFT belongs to S0 (memory rail ramping)
    typedef enum logic [2:0] {
        ST_S5, ST_SOFT, ST_S0, ST_S3, ST_TRIP
    } slp_state_t;

    // Sensed inputs, one bit each
    typedef struct packed {
        logic sleep_request;
        logic standby_supply_ok;
        logic main_supply_ok;
        logic reference_good;
        logic memory_rail_ok;
        logic overcurrent;
        logic temp_hot;
        logic temp_cool;
    } slp_sense_t;
    localparam int SENSE_W = $bits(slp_sense_t);

    // Gate-drive outputs
    typedef struct packed {
        logic memory_high_side_gate;
        logic memory_low_side_gate;
        logic core_high_side_gate;
        logic core_low_side_gate;
    } slp_gate_t;
endpackage : slp_pkg

//--- verification/slp_host_model.sv
// Partner model: system power manager that drives the sleep request
module slp_host_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       want_sleep,
    input  wire logic [3:0] lag,
    input  wire logic [1:0] sleep_mode,
    output logic            sleep_request
);
    // ------------------------------------------------------------
    // Request logic
    // ------------------------------------------------------------
    logic [3:0] wait_q;

    // Raise only once S0 is seen, after a chosen lag; drop on command
    always_ff @(posedge aclk) begin
        if (!aresetn || !want_sleep) begin
            sleep_request <= 1'b0;
            wait_q        <= 4'h0;
        end else if (sleep_mode == 2'h1 && wait_q >= lag) begin
            sleep_request <= 1'b1;
        end else if (sleep_mode == 2'h1) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : slp_host_model

//--- verification/slp_sequencer_tb_top.sv
// Testbench: walks the sequencer through its modes and its register bus
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    num_errors++; $display("mismatch at %0t: got %h expected %h", \
    $time, (a), (e)); end end
module slp_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import slp_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        aclk = 1'b0, aresetn = 1'b0, want_sleep = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, host_sleep;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, sleep_mode, r;
    logic        sb_good, gs_good, in_reg, term_en, core_en, hs_q = 1'b0;
    slp_sense_t  sns = '0, sense;
    slp_gate_t   gate;
    int          num_errors = 0, total_checks = 0;
    int          cyc = 0, last_rise = 0, rise_gap = 0;
    logic [1:0]  mode_prev = 2'h0;

    // 25 MHz clock
    always #20 aclk = ~aclk;

    // Host owns the sleep bit, the bench owns the rest of the sense bus
    always_comb begin
        sense = sns;
        sense.sleep_request = host_sleep;
    end

    slp_host_model host (.aclk(aclk), .aresetn(aresetn),
        .want_sleep(want_sleep), .lag(4'h3), .sleep_mode(sleep_mode),
        .sleep_request(host_sleep));

    slp_sequencer dut (.aclk(aclk), .aresetn(aresetn), .sense(sense),
        .gate(gate), .standby_supply_good(sb_good),
        .gate_supply_good(gs_good), .memory_rail_in_regulation(in_reg),
        .termination_enable(term_en), .core_rail_enable(core_en),
        .sleep_mode(sleep_mode), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    // ------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------
    // Spacing of high-side rising edges gives the switching period
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        hs_q <= gate.memory_high_side_gate;
        if (gate.memory_high_side_gate === 1'b1 && hs_q === 1'b0) begin
            rise_gap  <= cyc - last_rise;
            last_rise <= cyc;
        end
    end

    // Mid-cycle watch on gate pairs and per-mode pin states
    always @(negedge aclk) begin
        if (aresetn) begin
            `CHK(gate[3] & gate[2] | gate[1] & gate[0], 1'b0)
            `CHK({mode_prev, sleep_mode} == 4'hc, 1'b0)
            `CHK({mode_prev, sleep_mode} == 4'h3, 1'b0)
            if (sleep_mode === 2'h0)
                `CHK({gate, term_en, core_en}, 6'h0)
            if (sleep_mode === 2'h3)
                `CHK({gate[1:0], term_en, core_en}, 4'h0)
            mode_prev = sleep_mode;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 3000) begin
            $display("timeout at %0t", $time);
            num_errors++;
            complete_run();
        end
    endtask : tick

    // Bus write: address and data offered together, each released when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v,
                      input logic [3:0] s, output logic [1:0] rsp);
        int n = 0;
        bit ad = 0, dd = 0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= v;
        wstrb   <= s;
        bready  <= 1'b1;
        while (!(ad && dd)) begin
            tick(n);
            if (!ad && awready === 1'b1) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!dd && wready === 1'b1) begin
                dd = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) tick(n);
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr

    // Bus read: ready held up from the start until the answer is seen
    task automatic rd(input logic [3:0] a, output logic [31:0] v,
                      output logic [1:0] rsp);
        int n = 0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do tick(n); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) tick(n);
        v = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : rd

    // Poll the state code; the soft-start alone takes 2500 cycles
    task automatic wait_state(input logic [2:0] code);
        int n = 0;
        do begin
            rd(ADDR_STAT, d, r);
            n++;
        end while (d[2:0] !== code && n < 1500);
        `CHK(d[2:0], code)
        // Stop only on a real miss, never on a match at the last poll
        if (d[2:0] !== code) complete_run();
    endtask : wait_state

    task automatic done(input string s);
        $display("test %s finished, %0d errors", s, num_errors);
    endtask : done

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK({sleep_mode, gate, term_en, core_en}, 8'h0)
        sns.standby_supply_ok <= 1'b1;
        sns.memory_rail_ok <= 1'b1;
        repeat (20) @(posedge aclk);
        `CHK({sb_good, gs_good, sleep_mode}, 4'h0)
        sns.reference_good <= 1'b1;
        repeat (30) @(posedge aclk);
        `CHK({sb_good, gs_good, sleep_mode}, 4'h8)
        wait_state(3'h0);
        sns.main_supply_ok <= 1'b1;
        wait_state(3'h1);
        `CHK({sb_good, gs_good, in_reg}, 3'h6)
        wait_state(3'h2);
        repeat (4) @(posedge aclk);
        `CHK({in_reg, term_en, core_en}, 3'h7)
        repeat (300) @(posedge aclk);
        `CHK(rise_gap, PWM_S0_CYC)
        done("power_up");
        rd(ADDR_CTRL, d, r);
        `CHK({r, d}, {RESP_OKAY, 16'h0, DUTY_RST, DUTY_RST})
        wr(ADDR_CTRL, 32'hffff_1e28, 4'hf, r);
        wr(ADDR_CTRL, 32'hffff_ff0a, 4'h1, r);
        rd(ADDR_CTRL, d, r);
        `CHK({r, d}, {RESP_OKAY, 32'h0000_1e0a})
        wr(ADDR_STAT, 32'hffff_ffff, 4'hf, r);
        `CHK(r, RESP_OKAY)
        rd(ADDR_STAT, d, r);
        `CHK(d[7:0], 8'h72)
        rd(4'h8, d, r);
        `CHK({r, d}, {RESP_SLV, 32'h0})
        wr(4'hc, 32'h1, 4'hf, r);
        `CHK(r, RESP_SLV)
        done("registers");
        want_sleep <= 1'b1;
        wait_state(3'h3);
        repeat (200) @(posedge aclk);
        `CHK(rise_gap, PWM_S3_CYC)
        sns.overcurrent <= 1'b1;
        repeat (10) @(posedge aclk);
        sns.overcurrent <= 1'b0;
        sns.main_supply_ok <= 1'b0;
        repeat (10) @(posedge aclk);
        `CHK(gs_good, 1'b0)
        wait_state(3'h3);
        sns.main_supply_ok <= 1'b1;
        want_sleep <= 1'b0;
        wait_state(3'h2);
        `CHK(in_reg, 1'b1)
        done("sleep");
        sns.temp_hot <= 1'b1;
        repeat (8) @(posedge aclk);
        `CHK({gate, term_en, core_en}, 6'h0)
        sns.temp_hot <= 1'b0;
        rd(ADDR_STAT, d, r);
        `CHK({d[7], term_en}, 2'h2)
        sns.temp_cool <= 1'b1;
        repeat (8) @(posedge aclk);
        sns.temp_cool <= 1'b0;
        rd(ADDR_STAT, d, r);
        `CHK({d[7], term_en}, 2'h1)
        done("thermal");
        sns.overcurrent <= 1'b1;
        wait_state(3'h4);
        sns.overcurrent <= 1'b0;
        repeat (10) @(posedge aclk);
        wait_state(3'h4);
        sns.standby_supply_ok <= 1'b0;
        wait_state(3'h0);
        sns.standby_supply_ok <= 1'b1;
        wait_state(3'h2);
        sns.main_supply_ok <= 1'b0;
        wait_state(3'h0);
        done("faults");
        complete_run();
    end
endmodule : slp_sequencer_tb_top
